// ---- hdl/lsd_pkg.sv ----
// constants, carrier types and decode functions for the lcd setup decoder
// assumes host bytes arrive already synchronous to i_ref_clk
package lsd_pkg;
  localparam logic [7:0] CMD_SYSTEM_SET = 8'h40;
  localparam logic [7:0] CMD_SCROLL = 8'h44;
  localparam logic [7:0] CMD_PIXEL_SHIFT = 8'h5A;
  localparam logic [7:0] CMD_LAYER_COMBINE = 8'h5B;
  localparam logic [7:0] CMD_MEMORY_WRITE = 8'h42;
  localparam logic [4:0] OFS_SYSTEM_MODE_FLAGS = 5'h00;
  localparam logic [4:0] OFS_CHAR_WIDTH_AND_DRIVE = 5'h01;
  localparam logic [4:0] OFS_CHAR_HEIGHT = 5'h02;
  localparam logic [4:0] OFS_ADDRESSES_PER_LINE = 5'h03;
  localparam logic [4:0] OFS_TOTAL_LINE_SPAN = 5'h04;
  localparam logic [4:0] OFS_LINES_PER_FRAME = 5'h05;
  localparam logic [4:0] OFS_VIRTUAL_WIDTH_LOW = 5'h06;
  localparam logic [4:0] OFS_VIRTUAL_WIDTH_HIGH = 5'h07;
  localparam logic [4:0] OFS_BLOCK1_START_LOW = 5'h0B;
  localparam logic [4:0] OFS_BLOCK1_START_HIGH = 5'h0C;
  localparam logic [4:0] OFS_BLOCK1_LINE_COUNT = 5'h0D;
  localparam logic [4:0] OFS_BLOCK2_START_LOW = 5'h0E;
  localparam logic [4:0] OFS_BLOCK2_START_HIGH = 5'h0F;
  localparam logic [4:0] OFS_BLOCK2_LINE_COUNT = 5'h10;
  localparam logic [4:0] OFS_BLOCK3_START_LOW = 5'h11;
  localparam logic [4:0] OFS_BLOCK3_START_HIGH = 5'h12;
  localparam logic [4:0] OFS_BLOCK4_START_LOW = 5'h13;
  localparam logic [4:0] OFS_BLOCK4_START_HIGH = 5'h14;
  localparam logic [4:0] OFS_LAYER_OVERLAY_CONTROL = 5'h18;
  localparam logic [4:0] OFS_HORIZONTAL_PIXEL_SHIFT = 5'h1B;
  localparam int REG_DEPTH = 32;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int BIT_CHAR_SOURCE = 0;
  localparam int BIT_CHAR_HEIGHT = 2;
  localparam int BIT_PANEL_DRIVE = 3;
  localparam int BIT_TOP_LINE = 5;
  localparam int BIT_AC_DRIVE = 7;
  localparam logic [7:0] PIXEL_SHIFT_MASK = 8'h07;
  localparam logic [3:0] SYSTEM_PARAMS = 4'h8;
  localparam logic [3:0] SCROLL_PARAMS = 4'hA;
  localparam logic [3:0] SINGLE_PARAMS = 4'h1;
  localparam logic [3:0] IDX_MAX = 4'hF;

  typedef enum logic [2:0] {
    LSD_IDLE, LSD_SYSTEM, LSD_SCROLL, LSD_PIXEL, LSD_OVERLAY, LSD_MEMWRITE
  } lsd_cmd_type;
  typedef struct packed {logic valid; logic is_cmd; logic [7:0] data;} lsd_bus_wr_type;
  typedef struct packed {logic en; logic [4:0] addr; logic [7:0] data;} lsd_reg_wr_type;
  typedef struct packed {logic hit; logic [4:0] addr;} lsd_slot_type;
  typedef struct packed {
    lsd_cmd_type cmd;
    logic [3:0] idx;
    lsd_reg_wr_type wr;
    logic mem_valid;
    logic [7:0] mem_data;
  } lsd_dec_state_type;
  typedef struct packed {
    logic char_source_select;
    logic char_height_select;
    logic panel_drive_select;
    logic top_line_compensation;
    logic [3:0] char_width_field;
    logic ac_drive_select;
    logic [3:0] char_height_field;
    logic [7:0] addresses_per_line;
    logic [7:0] total_line_span;
    logic [7:0] lines_per_frame;
    logic [15:0] virtual_width;
    logic [15:0] block1_start;
    logic [7:0] block1_line_count;
    logic [15:0] block2_start;
    logic [7:0] block2_line_count;
    logic [15:0] block3_start;
    logic [15:0] block4_start;
    logic [1:0] layer_combine_method;
    logic [1:0] block_text_graphics_select;
    logic [2:0] pixel_shift;
  } lsd_cfg_type;

  function automatic lsd_cmd_type lsd_decode_cmd(input logic [7:0] code);
    case (code)
      CMD_SYSTEM_SET: lsd_decode_cmd = LSD_SYSTEM;
      CMD_SCROLL: lsd_decode_cmd = LSD_SCROLL;
      CMD_PIXEL_SHIFT: lsd_decode_cmd = LSD_PIXEL;
      CMD_LAYER_COMBINE: lsd_decode_cmd = LSD_OVERLAY;
      CMD_MEMORY_WRITE: lsd_decode_cmd = LSD_MEMWRITE;
      default: lsd_decode_cmd = LSD_IDLE;
    endcase
  endfunction

  // register slot of parameter idx of a command; surplus parameters miss
  function automatic lsd_slot_type lsd_param_slot(input lsd_cmd_type cmd,
                                                  input logic [3:0] idx);
    lsd_param_slot = '0;
    case (cmd)
      LSD_SYSTEM: lsd_param_slot = '{idx < SYSTEM_PARAMS,
                                     5'(OFS_SYSTEM_MODE_FLAGS + {1'b0, idx})};
      LSD_SCROLL: lsd_param_slot = '{idx < SCROLL_PARAMS,
                                     5'(OFS_BLOCK1_START_LOW + {1'b0, idx})};
      LSD_PIXEL: lsd_param_slot = '{idx < SINGLE_PARAMS, OFS_HORIZONTAL_PIXEL_SHIFT};
      LSD_OVERLAY: lsd_param_slot = '{idx < SINGLE_PARAMS, OFS_LAYER_OVERLAY_CONTROL};
      default: lsd_param_slot = '0;
    endcase
  endfunction
endpackage

// ---- hdl/lsd_host_strobe.sv ----
// host write strobe capture: one pulse per write strobe taken with chip select low
// assumes cs, wr and select are synchronous to i_ref_clk
`timescale 1ns/1ps
module lsd_host_strobe import lsd_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_cs_n,
  input wire logic i_wr_n,
  input wire logic i_command_parameter_select,
  input wire logic [7:0] i_data,
  output lsd_bus_wr_type o_wr
);
  typedef struct packed {logic wr_n_prev; lsd_bus_wr_type wr;} lsd_strobe_state_type;
  lsd_strobe_state_type st_q;
  lsd_strobe_state_type st_d;

  // take on the falling strobe edge so a long strobe counts once
  always_comb begin
    st_d = st_q;
    st_d.wr_n_prev = i_wr_n;
    st_d.wr.valid = st_q.wr_n_prev && !i_wr_n && !i_cs_n;
    if (st_d.wr.valid) begin
      st_d.wr.is_cmd = i_command_parameter_select;
      st_d.wr.data = i_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= '{wr_n_prev: 1'b1, wr: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_wr = st_q.wr;

  property p_no_strobe_unselected;
    @(posedge i_ref_clk) disable iff (!i_reset_n) i_cs_n |=> !o_wr.valid;
  endproperty
  a_no_strobe_unselected: assert property (p_no_strobe_unselected)
    else $error("write taken while chip select high");
endmodule

// ---- hdl/lsd_reg_bank.sv ----
// configuration register array written one byte at a time
// assumes at most one write per clock from the decoder
`timescale 1ns/1ps
module lsd_reg_bank import lsd_pkg::*; #(
  parameter int DEPTH = REG_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input lsd_reg_wr_type i_wr,
  output logic [DEPTH-1:0][7:0] o_regs
);
  if (DEPTH < 28 || DEPTH > 32) begin : g_bad_depth
    $error("register depth must cover offsets up to 1Bh within 5 address bits");
  end

  typedef struct packed {logic [DEPTH-1:0][7:0] regs;} lsd_bank_state_type;
  lsd_bank_state_type st_q;
  lsd_bank_state_type st_d;

  always_comb begin
    st_d = st_q;
    if (i_wr.en) begin
      st_d.regs[i_wr.addr] = i_wr.data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= '{regs: {DEPTH{REG_RESET}}};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_regs = st_q.regs;
endmodule

// ---- hdl/lsd_setup_decoder.sv ----
// command and parameter decoder loading the display setup registers
// assumes host pins synchronous to i_ref_clk; display engine reads o_cfg
`timescale 1ns/1ps
module lsd_setup_decoder import lsd_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_cs_n,
  input wire logic i_wr_n,
  input wire logic i_command_parameter_select,
  input wire logic [7:0] i_data,
  output lsd_cfg_type o_cfg,
  output lsd_cmd_type o_active_command,
  output logic o_mem_data_valid,
  output logic [7:0] o_mem_data
);
  ////////////////////////////////////////////////////////////////////////////
  lsd_bus_wr_type bus_wr;
  lsd_dec_state_type st_q;
  lsd_dec_state_type st_d;
  lsd_slot_type slot;
  logic [REG_DEPTH-1:0][7:0] regs;

  lsd_host_strobe u_strobe (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_cs_n(i_cs_n),
    .i_wr_n(i_wr_n),
    .i_command_parameter_select(i_command_parameter_select),
    .i_data(i_data),
    .o_wr(bus_wr)
  );

  lsd_reg_bank #(
    .DEPTH(REG_DEPTH)
  ) u_bank (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_wr(st_q.wr),
    .o_regs(regs)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.wr = '0;
    st_d.mem_valid = 1'b0;
    slot = lsd_param_slot(st_q.cmd, st_q.idx);
    if (bus_wr.valid && bus_wr.is_cmd) begin
      st_d.cmd = lsd_decode_cmd(bus_wr.data);
      st_d.idx = 4'h0;
    end else if (bus_wr.valid) begin
      // saturate so a long surplus list never wraps onto slot 0
      if (st_q.idx != IDX_MAX) begin
        st_d.idx = 4'(st_q.idx + 4'h1);
      end
      case (st_q.cmd)
        LSD_MEMWRITE: begin
          // display data goes on to the memory port, not the registers
          st_d.mem_valid = 1'b1;
          st_d.mem_data = bus_wr.data;
        end
        LSD_SYSTEM, LSD_SCROLL, LSD_OVERLAY: begin
          st_d.wr.en = slot.hit;
          st_d.wr.addr = slot.addr;
          st_d.wr.data = bus_wr.data;
        end
        LSD_PIXEL: begin
          st_d.wr.en = slot.hit;
          st_d.wr.addr = slot.addr;
          st_d.wr.data = bus_wr.data & PIXEL_SHIFT_MASK;
        end
        default: begin
          st_d.wr = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= '{cmd: LSD_IDLE, idx: 4'h0, wr: '0, mem_valid: 1'b0, mem_data: 8'h00};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field view of the register array
  always_comb begin
    o_cfg = '0;
    o_cfg.char_source_select = regs[OFS_SYSTEM_MODE_FLAGS][BIT_CHAR_SOURCE];
    o_cfg.char_height_select = regs[OFS_SYSTEM_MODE_FLAGS][BIT_CHAR_HEIGHT];
    o_cfg.panel_drive_select = regs[OFS_SYSTEM_MODE_FLAGS][BIT_PANEL_DRIVE];
    o_cfg.top_line_compensation = regs[OFS_SYSTEM_MODE_FLAGS][BIT_TOP_LINE];
    o_cfg.char_width_field = regs[OFS_CHAR_WIDTH_AND_DRIVE][3:0];
    o_cfg.ac_drive_select = regs[OFS_CHAR_WIDTH_AND_DRIVE][BIT_AC_DRIVE];
    o_cfg.char_height_field = regs[OFS_CHAR_HEIGHT][3:0];
    o_cfg.addresses_per_line = regs[OFS_ADDRESSES_PER_LINE];
    o_cfg.total_line_span = regs[OFS_TOTAL_LINE_SPAN];
    o_cfg.lines_per_frame = regs[OFS_LINES_PER_FRAME];
    o_cfg.virtual_width = {regs[OFS_VIRTUAL_WIDTH_HIGH],
                           regs[OFS_VIRTUAL_WIDTH_LOW]};
    o_cfg.block1_start = {regs[OFS_BLOCK1_START_HIGH],
                          regs[OFS_BLOCK1_START_LOW]};
    o_cfg.block1_line_count = regs[OFS_BLOCK1_LINE_COUNT];
    o_cfg.block2_start = {regs[OFS_BLOCK2_START_HIGH],
                          regs[OFS_BLOCK2_START_LOW]};
    o_cfg.block2_line_count = regs[OFS_BLOCK2_LINE_COUNT];
    o_cfg.block3_start = {regs[OFS_BLOCK3_START_HIGH],
                          regs[OFS_BLOCK3_START_LOW]};
    o_cfg.block4_start = {regs[OFS_BLOCK4_START_HIGH],
                          regs[OFS_BLOCK4_START_LOW]};
    o_cfg.layer_combine_method = regs[OFS_LAYER_OVERLAY_CONTROL][1:0];
    o_cfg.block_text_graphics_select = regs[OFS_LAYER_OVERLAY_CONTROL][3:2];
    o_cfg.pixel_shift = regs[OFS_HORIZONTAL_PIXEL_SHIFT][2:0];
  end

  assign o_active_command = st_q.cmd;
  assign o_mem_data_valid = st_q.mem_valid;
  assign o_mem_data = st_q.mem_data;

  ////////////////////////////////////////////////////////////////////////////
  // checks: a parameter taken at cycle t shows on o_cfg at t+2
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  logic ev_par;
  logic ev_sys;
  logic ev_scr;
  logic [7:0] par_byte;
  assign ev_par = bus_wr.valid && !bus_wr.is_cmd;
  assign ev_sys = ev_par && st_q.cmd == LSD_SYSTEM;
  assign ev_scr = ev_par && st_q.cmd == LSD_SCROLL;
  assign par_byte = bus_wr.data;

  property p_char_source;
    ev_sys && st_q.idx == 4'h0 |-> ##2 o_cfg.char_source_select == $past(par_byte[0], 2);
  endproperty
  a_char_source: assert property (p_char_source)
    else $error("character source not loaded from first parameter");

  property p_char_height_sel;
    ev_sys && st_q.idx == 4'h0 |-> ##2 o_cfg.char_height_select == $past(par_byte[2], 2);
  endproperty
  a_char_height_sel: assert property (p_char_height_sel)
    else $error("character height select wrong");

  property p_panel_drive;
    ev_sys && st_q.idx == 4'h0 |-> ##2 o_cfg.panel_drive_select == $past(par_byte[3], 2);
  endproperty
  a_panel_drive: assert property (p_panel_drive)
    else $error("panel drive select wrong");

  property p_top_line;
    ev_sys && st_q.idx == 4'h0
      |-> ##2 o_cfg.top_line_compensation == $past(par_byte[5], 2);
  endproperty
  a_top_line: assert property (p_top_line)
    else $error("top-line compensation wrong");

  property p_char_width;
    ev_sys && st_q.idx == 4'h1 |-> ##2 o_cfg.char_width_field == $past(par_byte[3:0], 2);
  endproperty
  a_char_width: assert property (p_char_width)
    else $error("character width field wrong");

  property p_ac_drive;
    ev_sys && st_q.idx == 4'h1 |-> ##2 o_cfg.ac_drive_select == $past(par_byte[7], 2);
  endproperty
  a_ac_drive: assert property (p_ac_drive)
    else $error("ac drive select wrong");

  property p_char_height;
    ev_sys && st_q.idx == 4'h2 |-> ##2 o_cfg.char_height_field == $past(par_byte[3:0], 2);
  endproperty
  a_char_height: assert property (p_char_height)
    else $error("character height field wrong");

  property p_addr_per_line;
    ev_sys && st_q.idx == 4'h3 |-> ##2 o_cfg.addresses_per_line == $past(par_byte, 2);
  endproperty
  a_addr_per_line: assert property (p_addr_per_line)
    else $error("addresses per line wrong");

  property p_line_span;
    ev_sys && st_q.idx == 4'h4 |-> ##2 o_cfg.total_line_span == $past(par_byte, 2);
  endproperty
  a_line_span: assert property (p_line_span)
    else $error("total line span wrong");

  property p_lines_frame;
    ev_sys && st_q.idx == 4'h5 |-> ##2 o_cfg.lines_per_frame == $past(par_byte, 2);
  endproperty
  a_lines_frame: assert property (p_lines_frame)
    else $error("lines per frame wrong");

  property p_virtual_width;
    ev_sys && st_q.idx == 4'h7 |-> ##2 o_cfg.virtual_width[15:8] == $past(par_byte, 2)
      && o_cfg.virtual_width[7:0] == $past(o_cfg.virtual_width[7:0], 2);
  endproperty
  a_virtual_width: assert property (p_virtual_width)
    else $error("virtual width high byte wrong");

  property p_block1_start;
    ev_scr && st_q.idx == 4'h1 |-> ##2 o_cfg.block1_start[15:8] == $past(par_byte, 2);
  endproperty
  a_block1_start: assert property (p_block1_start)
    else $error("block 1 start high byte wrong");

  property p_block1_lines;
    ev_scr && st_q.idx == 4'h2 |-> ##2 o_cfg.block1_line_count == $past(par_byte, 2);
  endproperty
  a_block1_lines: assert property (p_block1_lines)
    else $error("block 1 line count wrong");

  property p_block2_start;
    ev_scr && st_q.idx == 4'h4 |-> ##2 o_cfg.block2_start[15:8] == $past(par_byte, 2);
  endproperty
  a_block2_start: assert property (p_block2_start)
    else $error("block 2 start high byte wrong");

  property p_block2_lines;
    ev_scr && st_q.idx == 4'h5 |-> ##2 o_cfg.block2_line_count == $past(par_byte, 2);
  endproperty
  a_block2_lines: assert property (p_block2_lines)
    else $error("block 2 line count wrong");

  property p_block3_start;
    ev_scr && st_q.idx == 4'h6 |-> ##2 o_cfg.block3_start[7:0] == $past(par_byte, 2);
  endproperty
  a_block3_start: assert property (p_block3_start)
    else $error("block 3 start low byte wrong");

  property p_block4_start;
    ev_scr && st_q.idx == 4'h9 |-> ##2 o_cfg.block4_start[15:8] == $past(par_byte, 2);
  endproperty
  a_block4_start: assert property (p_block4_start)
    else $error("block 4 start high byte wrong");

  property p_pixel_shift;
    ev_par && st_q.cmd == LSD_PIXEL && st_q.idx == 4'h0
      |-> ##2 o_cfg.pixel_shift == $past(par_byte[2:0], 2)
      && regs[OFS_HORIZONTAL_PIXEL_SHIFT][7:3] == 5'h00;
  endproperty
  a_pixel_shift: assert property (p_pixel_shift)
    else $error("pixel shift wrong or upper bits kept");

  property p_combine;
    ev_par && st_q.cmd == LSD_OVERLAY && st_q.idx == 4'h0
      |-> ##2 o_cfg.layer_combine_method == $past(par_byte[1:0], 2);
  endproperty
  a_combine: assert property (p_combine)
    else $error("layer combine method wrong");

  property p_block_mode;
    ev_par && st_q.cmd == LSD_OVERLAY && st_q.idx == 4'h0
      |-> ##2 o_cfg.block_text_graphics_select == $past(par_byte[3:2], 2);
  endproperty
  a_block_mode: assert property (p_block_mode)
    else $error("block text/graphics select wrong");

  property p_cmd_decode;
    bus_wr.valid && bus_wr.is_cmd |=> st_q.cmd == lsd_decode_cmd($past(par_byte));
  endproperty
  a_cmd_decode: assert property (p_cmd_decode)
    else $error("command byte not decoded");

  property p_param_keeps_cmd;
    ev_par |=> $stable(st_q.cmd) && !st_q.mem_valid == ($past(st_q.cmd) != LSD_MEMWRITE);
  endproperty
  a_param_keeps_cmd: assert property (p_param_keeps_cmd)
    else $error("parameter write disturbed command or memory path");

  property p_idx_restart;
    bus_wr.valid && bus_wr.is_cmd |=> st_q.idx == 4'h0 ##1 st_q.wr.en == 1'b0;
  endproperty
  a_idx_restart: assert property (p_idx_restart)
    else $error("parameter index not restarted by command");

  property p_idx_advance;
    ev_par && st_q.idx != IDX_MAX |=> st_q.idx == $past(st_q.idx) + 4'h1;
  endproperty
  a_idx_advance: assert property (p_idx_advance)
    else $error("parameter index did not advance");

  property p_surplus_ignored;
    ev_par && !slot.hit |=> !st_q.wr.en;
  endproperty
  a_surplus_ignored: assert property (p_surplus_ignored)
    else $error("surplus parameter wrote a register");

  property p_idle_ignored;
    ev_par && st_q.cmd == LSD_IDLE |=> !st_q.wr.en ##1 $stable(regs);
  endproperty
  a_idle_ignored: assert property (p_idle_ignored)
    else $error("parameter without known command wrote a register");

  property p_virtual_width_low;
    ev_sys && st_q.idx == 4'h6 |-> ##2 o_cfg.virtual_width[7:0] == $past(par_byte, 2);
  endproperty
  a_virtual_width_low: assert property (p_virtual_width_low)
    else $error("virtual width low byte wrong");

  property p_block1_start_low;
    ev_scr && st_q.idx == 4'h0 |-> ##2 o_cfg.block1_start[7:0] == $past(par_byte, 2);
  endproperty
  a_block1_start_low: assert property (p_block1_start_low)
    else $error("block 1 start low byte wrong");

  property p_block2_start_low;
    ev_scr && st_q.idx == 4'h3 |-> ##2 o_cfg.block2_start[7:0] == $past(par_byte, 2);
  endproperty
  a_block2_start_low: assert property (p_block2_start_low)
    else $error("block 2 start low byte wrong");

  property p_block3_start_high;
    ev_scr && st_q.idx == 4'h7 |-> ##2 o_cfg.block3_start[15:8] == $past(par_byte, 2);
  endproperty
  a_block3_start_high: assert property (p_block3_start_high)
    else $error("block 3 start high byte wrong");

  property p_block4_start_low;
    ev_scr && st_q.idx == 4'h8 |-> ##2 o_cfg.block4_start[7:0] == $past(par_byte, 2);
  endproperty
  a_block4_start_low: assert property (p_block4_start_low)
    else $error("block 4 start low byte wrong");

  property p_mem_forward;
    ev_par && st_q.cmd == LSD_MEMWRITE |=> st_q.mem_valid && st_q.mem_data == $past(par_byte);
  endproperty
  a_mem_forward: assert property (p_mem_forward)
    else $error("display data byte not forwarded");

  property p_mem_pulse;
    st_q.mem_valid |=> !st_q.mem_valid;
  endproperty
  a_mem_pulse: assert property (p_mem_pulse)
    else $error("display data strobe longer than one cycle");

  property p_cmd_no_reg_write;
    bus_wr.valid && bus_wr.is_cmd |=> !st_q.wr.en;
  endproperty
  a_cmd_no_reg_write: assert property (p_cmd_no_reg_write)
    else $error("command byte wrote a register");
endmodule

// ---- bench/lsd_host_model.sv ----
// host bus model: one write strobe per byte, command or parameter
// assumes put is called from a process clocked by i_ref_clk
`timescale 1ns/1ps
module lsd_host_model (
  input wire logic i_ref_clk,
  output logic o_cs_n,
  output logic o_wr_n,
  output logic o_command_parameter_select,
  output logic [7:0] o_data
);
  initial begin
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_command_parameter_select = 1'b0;
    o_data = 8'hA5;
  end
  ////////////////////////////////////////////////////////////////////////
  // select high with strobe is a command, low a parameter
  task automatic put(input logic cs_n, input logic sel, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_cs_n <= cs_n;
    o_command_parameter_select <= sel;
    o_data <= d;
    o_wr_n <= 1'b0;
    @(posedge i_ref_clk);
    o_wr_n <= 1'b1;
    o_cs_n <= 1'b1;
    // released bus: inverse so a stale byte never looks valid
    o_data <= ~d;
  endtask
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the setup decoder
// assumes the host model drives every bus input of the decoder
`timescale 1ns/1ps
module tb_top import lsd_pkg::*; ();
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic cs_n;
  logic wr_n;
  logic sel;
  logic [7:0] data;
  lsd_cfg_type cfg;
  lsd_cmd_type act;
  logic mem_v;
  logic [7:0] mem_d;
  int failures = 0;
  int check_count = 0;
  logic [7:0] sys_p [8] = '{8'h38, 8'h87, 8'h07, 8'h3F, 8'h49, 8'h7F, 8'h80, 8'h00};
  logic [7:0] scr_p [10] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h10, 8'h40, 8'h00, 8'h04,
                             8'h00, 8'h30};
  always #2.5 i_ref_clk = ~i_ref_clk;
  lsd_host_model i_lsd_host_model (.i_ref_clk(i_ref_clk), .o_cs_n(cs_n),
    .o_wr_n(wr_n), .o_command_parameter_select(sel), .o_data(data));
  lsd_setup_decoder i_lsd_setup_decoder (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_cs_n(cs_n), .i_wr_n(wr_n), .i_command_parameter_select(sel), .i_data(data),
    .o_cfg(cfg), .o_active_command(act), .o_mem_data_valid(mem_v), .o_mem_data(mem_d));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    i_lsd_host_model.put(1'b0, 1'b1, c);
  endtask
  task automatic par(input logic [7:0] p);
    i_lsd_host_model.put(1'b0, 1'b0, p);
  endtask
  // field lands two edges after the taking edge
  task automatic settle();
    repeat (4) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic complete_run();
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    failures++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    #1;
    chk("cfg_reset", 16'h0000, 16'(|cfg));
    chk("act_reset", 16'(LSD_IDLE), 16'(act));
    // power-up order: setup, scroll, pixel shift, overlay
    cmd(CMD_SYSTEM_SET);
    for (int i = 0; i < 8; i++) begin
      par(sys_p[i]); // counts written minus one
    end
    settle();
    chk("act_sys", 16'(LSD_SYSTEM), 16'(act));
    chk("src", 16'h0000, 16'(cfg.char_source_select));
    chk("hsel", 16'h0000, 16'(cfg.char_height_select));
    chk("panel", 16'h0001, 16'(cfg.panel_drive_select));
    chk("topl", 16'h0001, 16'(cfg.top_line_compensation));
    chk("cwid", 16'h0007, 16'(cfg.char_width_field));
    chk("acdr", 16'h0001, 16'(cfg.ac_drive_select));
    chk("chgt", 16'h0007, 16'(cfg.char_height_field));
    chk("apl", 16'h003F, 16'(cfg.addresses_per_line));
    chk("span", 16'h0049, 16'(cfg.total_line_span));
    chk("lpf", 16'h007F, 16'(cfg.lines_per_frame));
    chk("vwid", 16'h0080, cfg.virtual_width);
    cmd(CMD_SCROLL);
    for (int i = 0; i < 10; i++) begin
      par(scr_p[i]);
    end
    settle();
    chk("b1s", 16'h0000, cfg.block1_start);
    chk("b1n", 16'h0040, 16'(cfg.block1_line_count));
    chk("b2s", 16'h1000, cfg.block2_start);
    chk("b2n", 16'h0040, 16'(cfg.block2_line_count));
    chk("b3s", 16'h0400, cfg.block3_start);
    chk("b4s", 16'h3000, cfg.block4_start);
    // deselected strobe ignored, surplus parameter dropped
    cmd(CMD_PIXEL_SHIFT);
    i_lsd_host_model.put(1'b1, 1'b0, 8'h06);
    par(8'hFB);
    par(8'h05);
    settle();
    chk("shift", 16'h0003, 16'(cfg.pixel_shift));
    cmd(CMD_LAYER_COMBINE);
    par(8'h0D);
    settle();
    chk("mix", 16'h0001, 16'(cfg.layer_combine_method));
    chk("dm", 16'h0003, 16'(cfg.block_text_graphics_select));
    // unknown code: idle, its parameter must not reach overlay
    cmd(8'h58);
    par(8'h02);
    settle();
    chk("act_unk", 16'(LSD_IDLE), 16'(act));
    chk("mix_kept", 16'h0001, 16'(cfg.layer_combine_method));
    // short lists: index restarts at every command
    cmd(CMD_SYSTEM_SET);
    par(8'h05);
    cmd(CMD_SCROLL);
    par(8'h12);
    settle();
    chk("src_re", 16'h0001, 16'(cfg.char_source_select));
    chk("panel_re", 16'h0000, 16'(cfg.panel_drive_select));
    chk("hsel_re", 16'h0001, 16'(cfg.char_height_select));
    chk("topl_re", 16'h0000, 16'(cfg.top_line_compensation));
    chk("cwid_kept", 16'h0007, 16'(cfg.char_width_field));
    chk("b1s_re", 16'h0012, cfg.block1_start);
    chk("b2s_kept", 16'h1000, cfg.block2_start);
    // text layer fill byte through memory write
    cmd(CMD_MEMORY_WRITE);
    par(8'h20);
    @(posedge i_ref_clk);
    #1;
    chk("mem_v", 16'h0001, 16'(mem_v));
    chk("mem_d", 16'h0020, 16'(mem_d));
    @(posedge i_ref_clk);
    #1;
    chk("mem_v_end", 16'h0000, 16'(mem_v));
    complete_run();
  end
endmodule
